// ==== tca_analyzer.sv ====
// capture engine with APB register file
`timescale 1ns/10ps
module tca_analyzer
	import tca_pkg::*;
#(
	parameter int DEPTH = 256,
	parameter int SIGW = 16,
	parameter int NSRC = 16
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// monitored logic
	input wire logic [SIGW-1:0] monSig,
	input wire logic [NSRC-1:0] extInSig,
	input wire logic [NSRC-1:0] cntSig,
	input wire logic hwCtrlStart,
	// nonvolatile copy of the settings
	input wire logic [31:0] flashCfg,
	input wire logic [31:0] flashPeriod,
	input wire logic [31:0] flashTotal,
	input wire logic [31:0] flashPre,
	output logic flashWr,
	output logic [31:0] flashWrCfg,
	output logic [31:0] flashWrPeriod,
	output logic [31:0] flashWrTotal,
	output logic [31:0] flashWrPre,
	// status
	output logic irq,
	output logic armed
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || SIGW > 32 || SIGW < 1 || NSRC > 16 || NSRC < 1)
	begin : g_badParams
		$error("tca_analyzer: unsupported parameters");
	end

	logic [31:0] cfg_r, period_r, total_r, pre_r;
	logic [IRQ_W-1:0] irqStat_r, irqMask_r;
	logic [AW-1:0] rdIdx_r, wrPtr_r, startPtr_r;
	logic [31:0] perCnt_r, postCnt_r, fill_r;
	logic [SIGW-1:0] mem [DEPTH];
	logic bootDone_r, trigPrev_r, hwPrev_r;
	tca_state_t state_r;

	function automatic logic [AW-1:0] ptrAdd(input logic [AW-1:0] a,
		input logic [31:0] b);
		logic [31:0] s;
		s = 32'(a) + b;
		ptrAdd = AW'(s % DEPTH);
	endfunction : ptrAdd

	// zero or oversize totals fall back to the full buffer
	function automatic logic [31:0] clampTotal(input logic [31:0] t);
		clampTotal = (t == 32'h0 || t > 32'(DEPTH)) ? 32'(DEPTH) : t;
	endfunction : clampTotal

	wire wrEn = psel && penable && pwrite;
	wire rdEn = psel && penable && !pwrite;
	wire ctrlWr = wrEn && paddr == TCA_CTRL;
	wire startCmd = ctrlWr && pwdata[CTRL_START];
	wire stopCmd = ctrlWr && pwdata[CTRL_STOP];
	wire delCmd = ctrlWr && pwdata[CTRL_DELETE];

	// trigger source and edge
	wire [CFG_SEL_W-1:0] sel = cfg_r[CFG_SEL_LO +: CFG_SEL_W];
	wire trigNow = cfg_r[CFG_SRC] ? cntSig[sel] : extInSig[sel];
	wire trigEdge = cfg_r[CFG_FALL] ? (trigPrev_r && !trigNow)
		: (!trigPrev_r && trigNow);
	wire tick = perCnt_r + 32'h1 >= period_r;
	wire hwRise = hwCtrlStart && !hwPrev_r;
	wire fired = state_r == TCA_ARMED && trigEdge
		&& fill_r >= pre_r;
	wire [31:0] postCount = total_r - pre_r;
	wire cfgWr = wrEn && !(state_r == TCA_ARMED
		|| state_r == TCA_POSTCAP);

	// configuration: power-on load, write, delete
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cfg_r <= CFG_RST;
			period_r <= PERIOD_RST;
			total_r <= 32'(DEPTH);
			pre_r <= 32'h0;
			bootDone_r <= 1'b0;
		end
		else if (!bootDone_r)
		begin
			bootDone_r <= 1'b1;
			cfg_r <= flashCfg;
			period_r <= (flashPeriod == 32'h0) ? PERIOD_RST : flashPeriod;
			total_r <= clampTotal(flashTotal);
			pre_r <= (flashPre > clampTotal(flashTotal)) ? 32'h0 : flashPre;
		end
		else if (delCmd)
		begin
			cfg_r <= CFG_RST;
			period_r <= PERIOD_RST;
			total_r <= 32'(DEPTH);
			pre_r <= 32'h0;
		end
		else if (cfgWr)
		begin
			case (paddr)
				TCA_CFG: cfg_r <= pwdata;
				TCA_PERIOD: period_r <= (pwdata == 32'h0) ? PERIOD_RST : pwdata;
				TCA_TOTAL:
				begin
					total_r <= clampTotal(pwdata);
					// keep pre within a shrinking total
					if (pre_r > clampTotal(pwdata))
						pre_r <= clampTotal(pwdata);
				end
				TCA_PRE: pre_r <= (pwdata > total_r) ? total_r : pwdata;
				default: ;
			endcase
		end
	end

	// flash write strobe with current settings
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			flashWr <= 1'b0;
			flashWrCfg <= 32'h0;
			flashWrPeriod <= 32'h0;
			flashWrTotal <= 32'h0;
			flashWrPre <= 32'h0;
		end
		else
		begin
			flashWr <= ctrlWr && pwdata[CTRL_FLASH];
			flashWrCfg <= cfg_r;
			flashWrPeriod <= period_r;
			flashWrTotal <= total_r;
			flashWrPre <= pre_r;
		end
	end

	// capture state machine
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_r <= TCA_STOPPED;
			trigPrev_r <= 1'b0;
			hwPrev_r <= 1'b0;
			perCnt_r <= 32'h0;
			postCnt_r <= 32'h0;
			fill_r <= 32'h0;
			wrPtr_r <= '0;
			startPtr_r <= '0;
		end
		else
		begin
			trigPrev_r <= trigNow;
			hwPrev_r <= hwCtrlStart;
			perCnt_r <= (tick || state_r == TCA_STOPPED
				|| state_r == TCA_DONE) ? 32'h0 : perCnt_r + 32'h1;
			case (state_r)
				TCA_STOPPED, TCA_DONE:
				begin
					if (startCmd || (hwRise && cfg_r[CFG_AUTO]))
					begin
						state_r <= TCA_ARMED;
						fill_r <= 32'h0;
						wrPtr_r <= '0;
					end
					else if (stopCmd)
						state_r <= TCA_STOPPED;
				end
				TCA_ARMED:
				begin
					if (stopCmd)
						state_r <= TCA_STOPPED;
					else if (fired)
					begin
						startPtr_r <= ptrAdd(wrPtr_r, 32'(DEPTH) - pre_r);
						postCnt_r <= 32'h0;
						state_r <= (postCount == 32'h0) ? TCA_DONE : TCA_POSTCAP;
					end
					else if (tick)
					begin
						wrPtr_r <= ptrAdd(wrPtr_r, 32'h1);
						if (fill_r < pre_r)
							fill_r <= fill_r + 32'h1;
					end
				end
				TCA_POSTCAP:
				begin
					if (stopCmd)
						state_r <= TCA_STOPPED;
					else if (tick)
					begin
						wrPtr_r <= ptrAdd(wrPtr_r, 32'h1);
						postCnt_r <= postCnt_r + 32'h1;
						if (postCnt_r + 32'h1 >= postCount)
							state_r <= TCA_DONE;
					end
				end
				default: state_r <= TCA_STOPPED;
			endcase
		end
	end

	// sample store
	always_ff @(posedge clk)
	begin
		if ((state_r == TCA_ARMED || state_r == TCA_POSTCAP) && tick)
			mem[wrPtr_r] <= monSig;
	end

	// interrupts
	wire [IRQ_W-1:0] irqSet = {state_r == TCA_POSTCAP && tick
		&& postCnt_r + 32'h1 >= postCount, fired};
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			irqStat_r <= '0;
			irqMask_r <= '0;
			irq <= 1'b0;
			armed <= 1'b0;
		end
		else
		begin
			irqStat_r <= (irqStat_r & ~((wrEn && paddr == TCA_IRQ)
				? pwdata[IRQ_W-1:0] : '0)) | irqSet;
			if (wrEn && paddr == TCA_MASK)
				irqMask_r <= pwdata[IRQ_W-1:0];
			irq <= |(irqStat_r & irqMask_r);
			armed <= state_r == TCA_ARMED;
		end
	end

	// read index and apb read data
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdIdx_r <= '0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			if (wrEn && paddr == TCA_RIDX)
				rdIdx_r <= pwdata[AW-1:0];
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr > TCA_RDATA;
			prdata <= 32'h0;
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
					TCA_CFG: prdata <= cfg_r;
					TCA_PERIOD: prdata <= period_r;
					TCA_TOTAL: prdata <= total_r;
					TCA_PRE: prdata <= pre_r;
					TCA_POST: prdata <= postCount;
					TCA_STAT: prdata <= {30'h0, state_r};
					TCA_IRQ: prdata <= 32'(irqStat_r);
					TCA_MASK: prdata <= 32'(irqMask_r);
					TCA_RIDX: prdata <= 32'(rdIdx_r);
					TCA_RDATA: prdata <= (state_r == TCA_DONE)
						? 32'(mem[ptrAdd(startPtr_r, 32'(rdIdx_r))])
						: 32'h0;
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	a_pre_bound: assert property (@(posedge clk) disable iff (!rst_n)
		pre_r <= total_r) else $error("pre count above total");
	a_auto_arm: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == TCA_STOPPED && hwRise && cfg_r[CFG_AUTO] && bootDone_r)
		|=> state_r == TCA_ARMED) else $error("auto arm missed");
	a_start_arm: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == TCA_STOPPED && startCmd) |=> state_r == TCA_ARMED)
		else $error("start did not arm");
	a_delete_clr: assert property (@(posedge clk) disable iff (!rst_n)
		(delCmd && bootDone_r) |=> cfg_r == CFG_RST)
		else $error("delete left config");
	a_post_calc: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == TCA_POSTCAP |-> postCnt_r < total_r - pre_r)
		else $error("post count wrong");
	a_flash_sel: assert property (@(posedge clk) disable iff (!rst_n)
		flashWr |-> $past(ctrlWr)) else $error("stray flash write");
	a_fire_edge: assert property (@(posedge clk) disable iff (!rst_n)
		fired |-> (trigNow != trigPrev_r && trigNow == !cfg_r[CFG_FALL]))
		else $error("fired without edge");
	a_done_cnt: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == TCA_POSTCAP ##1 state_r == TCA_DONE)
		|-> $past(postCnt_r) + 32'h1 == postCount)
		else $error("wrong sample total");
	a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
		|(irqStat_r & irqMask_r) |=> irq) else $error("irq not raised");
endmodule : tca_analyzer

// ==== tca_analyzer_tb_top.sv ====
// self-checking bench of the capture analyzer
`timescale 1ns/10ps
module tca_analyzer_tb_top
	import tca_pkg::*;
;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d;} tca_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, armed, flashWr, er;
	logic [15:0] monSig = 16'h0000, extInSig = 16'h0000, cntSig = 16'h0000;
	logic hwCtrlStart = 1'b0;
	logic [31:0] fCfg, fPer, fTot, fPre, wCfg, wPer, wTot, wPre;
	logic [31:0] s [0:5];
	int mismatches = 0, check_count = 0, cycles = 0;
	tca_row_t rows [14] = '{'{0, TCA_CFG, 32'h100}, '{0, TCA_PERIOD, 1},
		'{0, TCA_TOTAL, 8}, '{0, TCA_PRE, 3}, '{0, TCA_POST, 5},
		'{1, TCA_PERIOD, 2}, '{1, TCA_TOTAL, 6}, '{1, TCA_PRE, 4},
		'{0, TCA_PRE, 4}, '{1, TCA_PRE, 2}, '{0, TCA_POST, 4},
		'{0, TCA_STAT, 0}, '{1, TCA_MASK, 2}, '{0, TCA_MASK, 2}};

	tca_analyzer #(.DEPTH(8)) tca_analyzer_inst (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .monSig(monSig), .extInSig(extInSig),
		.cntSig(cntSig), .hwCtrlStart(hwCtrlStart), .flashCfg(fCfg),
		.flashPeriod(fPer), .flashTotal(fTot), .flashPre(fPre),
		.flashWr(flashWr), .flashWrCfg(wCfg), .flashWrPeriod(wPer),
		.flashWrTotal(wTot), .flashWrPre(wPre), .irq(irq), .armed(armed));
	tca_flash_model tca_flash_model_inst (.clk(clk), .flashWr(flashWr),
		.flashWrCfg(wCfg), .flashWrPeriod(wPer), .flashWrTotal(wTot),
		.flashWrPre(wPre), .flashCfg(fCfg), .flashPeriod(fPer),
		.flashTotal(fTot), .flashPre(fPre));

	always #2 clk = ~clk;
	always @(posedge clk) monSig <= monSig + 16'h0001;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc

	task automatic rst_seq();
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask : rst_seq

	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
	endtask : wait_irq

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	initial
	begin
		rst_seq();
		foreach (rows[i])
		begin
			if (rows[i].w)
				apb(1'b1, rows[i].a, rows[i].d);
			else
				rdc(rows[i].a, rows[i].d);
		end
		$display("register rows done");
		apb(1'b0, 8'h2C, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("unmapped test done");
		// rising edge of external input 1
		apb(1'b1, TCA_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, armed}, 32'h1);
		rdc(TCA_STAT, 32'h1);
		repeat (12) @(posedge clk);
		extInSig[1] <= 1'b1;
		wait_irq();
		chk({31'h0, irq}, 32'h1);
		rdc(TCA_STAT, 32'h3);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, TCA_RIDX, 32'(i));
			apb(1'b0, TCA_RDATA, 32'h0);
			s[i] = rd;
		end
		for (int i = 0; i < 5; i++)
		begin
			if (i != 1)
				chk(s[i+1] - s[i], 32'h2);
		end
		$display("capture test done");
		rdc(TCA_IRQ, 32'h3);
		apb(1'b1, TCA_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, TCA_MASK, 32'h2);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, TCA_IRQ, 32'h3);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdc(TCA_IRQ, 32'h0);
		$display("interrupt test done");
		// auto arm, falling edge of counter signal 3
		apb(1'b1, TCA_CTRL, 32'h2);
		rdc(TCA_STAT, 32'h0);
		cntSig[3] <= 1'b1;
		apb(1'b1, TCA_CFG, 32'h307);
		hwCtrlStart <= 1'b1;
		repeat (3) @(posedge clk);
		chk({31'h0, armed}, 32'h1);
		repeat (12) @(posedge clk);
		cntSig[3] <= 1'b0;
		wait_irq();
		rdc(TCA_STAT, 32'h3);
		hwCtrlStart <= 1'b0;
		$display("auto arm test done");
		apb(1'b1, TCA_CTRL, 32'h8);
		repeat (2) @(posedge clk);
		chk(fCfg, 32'h307);
		apb(1'b1, TCA_CTRL, 32'h4);
		rdc(TCA_CFG, CFG_RST);
		rst_seq();
		rdc(TCA_CFG, 32'h307);
		rdc(TCA_TOTAL, 32'h6);
		apb(1'b1, TCA_CTRL, 32'h1);
		apb(1'b1, TCA_PERIOD, 32'h5);
		rdc(TCA_PERIOD, 32'h2);
		$display("flash and delete test done");
		report_and_stop();
	end
endmodule : tca_analyzer_tb_top

// ==== tca_flash_model.sv ====
// nonvolatile settings store that sits beside the analyzer
`timescale 1ns/10ps
module tca_flash_model #(
	parameter logic [31:0] INIT_CFG = 32'h0000_0100,
	parameter logic [31:0] INIT_PERIOD = 32'h0000_0001,
	parameter logic [31:0] INIT_TOTAL = 32'h0000_0008,
	parameter logic [31:0] INIT_PRE = 32'h0000_0003
)(
	// clock
	input wire logic clk,
	// write side
	input wire logic flashWr,
	input wire logic [31:0] flashWrCfg,
	input wire logic [31:0] flashWrPeriod,
	input wire logic [31:0] flashWrTotal,
	input wire logic [31:0] flashWrPre,
	// stored contents
	output logic [31:0] flashCfg,
	output logic [31:0] flashPeriod,
	output logic [31:0] flashTotal,
	output logic [31:0] flashPre
);
	// contents at power-on, kept across resets
	logic [31:0] cfgKeep_r = INIT_CFG;
	logic [31:0] periodKeep_r = INIT_PERIOD;
	logic [31:0] totalKeep_r = INIT_TOTAL;
	logic [31:0] preKeep_r = INIT_PRE;
	assign flashCfg = cfgKeep_r;
	assign flashPeriod = periodKeep_r;
	assign flashTotal = totalKeep_r;
	assign flashPre = preKeep_r;
	always @(posedge clk)
	begin
		if (flashWr)
		begin
			cfgKeep_r <= flashWrCfg;
			periodKeep_r <= flashWrPeriod;
			totalKeep_r <= flashWrTotal;
			preKeep_r <= flashWrPre;
		end
	end
endmodule : tca_flash_model

// ==== tca_pkg.sv ====
// constants and register map of the trigger capture analyzer
package tca_pkg;
	localparam logic [7:0] TCA_CTRL = 8'h00;
	localparam logic [7:0] TCA_CFG = 8'h04;
	localparam logic [7:0] TCA_PERIOD = 8'h08;
	localparam logic [7:0] TCA_TOTAL = 8'h0C;
	localparam logic [7:0] TCA_PRE = 8'h10;
	localparam logic [7:0] TCA_POST = 8'h14;
	localparam logic [7:0] TCA_STAT = 8'h18;
	localparam logic [7:0] TCA_IRQ = 8'h1C;
	localparam logic [7:0] TCA_MASK = 8'h20;
	localparam logic [7:0] TCA_RIDX = 8'h24;
	localparam logic [7:0] TCA_RDATA = 8'h28;
	// control bits (write one = action)
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_DELETE = 2;
	localparam int CTRL_FLASH = 3;
	// configuration fields
	localparam int CFG_FALL = 0;
	localparam int CFG_AUTO = 1;
	localparam int CFG_SRC = 2;
	localparam int CFG_SEL_LO = 8;
	localparam int CFG_SEL_W = 4;
	// interrupt bits
	localparam int IRQ_TRIG = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_W = 2;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] PERIOD_RST = 32'h0000_0001;
	typedef enum logic [1:0] {TCA_STOPPED, TCA_ARMED, TCA_POSTCAP, TCA_DONE}
		tca_state_t;
endpackage : tca_pkg
